// ===== hdl/asc_pkg.sv
// Constants shared by the scan acquisition control block.
// Assumes a single 25 MHz system clock drives every file that uses it.
package asc_pkg;
   ////////////////////////////////////////////////////////////////////////
   // Clock and timebase ladder
   localparam int CLOCK_HZ = 25_000_000;    // System clock rate
   localparam int TB_TOP_HZ = 5_000_000;    // Fastest internal timebase
   localparam int TB_STAGES = 6;            // 5 MHz, 1 MHz, 100 kHz, 10 kHz, 1 kHz, 100 Hz
   // Divide ratio of stage 0 from the clock and of each later stage from the one before
   localparam int TB_DIV [0:5] = '{CLOCK_HZ / TB_TOP_HZ, 5, 10, 10, 10, 10};
   localparam logic [2:0] TB_SEL_EXT = 3'h6;  // Select code for the external count source
   ////////////////////////////////////////////////////////////////////////
   // Counter widths and encodings
   localparam int CNT_W = 16;               // Interval and sample count width
   localparam logic [CNT_W:0] CNT_START = 17'h00001;  // Count after preload 2 and step
   ////////////////////////////////////////////////////////////////////////
   // Result FIFO
   localparam int FIFO_DEPTH = 512;         // Result FIFO words
   localparam int FIFO_HALF = 256;          // Block readable once half flag shows
   localparam int DATA_W = 16;              // Conversion result width
   localparam int CFG_DEPTH = 64;           // Channel configuration entries
   localparam int CHAN_W = 6;               // Channel select width
   localparam int GAIN_W = 3;               // Gain code width
   ////////////////////////////////////////////////////////////////////////
   // Acquisition states
   typedef enum logic [1:0] {ASC_IDLE, ASC_PRE, ASC_RUN, ASC_HALT} asc_state_t;
endpackage

// ===== hdl/asc_interval_counter.sv
// Programmable interval counter: one pulse every N timebase ticks.
// Assumes tick is a one-cycle enable in the system clock domain.
`timescale 1ns/1ps
module asc_interval_counter #(
   parameter int W = 16
) (
   input wire logic clock,
   input wire logic rst,
   input wire logic restart,
   input wire logic run,
   input wire logic tick,
   input wire logic [W-1:0] load_value,
   output logic pulse
);
   logic [W:0] count_reg;   // Current count, one bit wider for 2**W
   logic [W:0] reload;      // Interval, zero standing for 2**W
   logic pulse_reg;         // Registered pulse out

   // Zero written means the full 2**W interval
   assign reload = (load_value == '0) ? {1'b1, {W{1'b0}}} : {1'b0, load_value};

   ////////////////////////////////////////////////////////////////////////
   // Count down; armed at 1 so the first tick after start fires
   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         count_reg <= asc_pkg::CNT_START;
      end else if (restart) begin
         count_reg <= asc_pkg::CNT_START;
      end else if (run && tick) begin
         if (count_reg == asc_pkg::CNT_START) begin
            count_reg <= reload;
         end else begin
            count_reg <= count_reg - 1'b1;
         end
      end
   end

   // Pulse on the tick that reaches the end of the interval
   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         pulse_reg <= 1'b0;
      end else begin
         pulse_reg <= !restart && run && tick && (count_reg == asc_pkg::CNT_START);
      end
   end

   assign pulse = pulse_reg;

   // Pulse only follows a tick seen at count one
   pulse_cause_a: assert property (@(posedge clock) disable iff (rst)
      pulse |-> $past(tick) && $past(run) && $past(count_reg) == asc_pkg::CNT_START)
      else $error("interval pulse without its cause");
endmodule

// ===== hdl/asc_top.sv
// Scan and sample sequencing, trigger handling and result FIFO for the
// analog-input acquisition path.
// Assumes all inputs are synchronous to clock; converter reports busy/valid.
//
// Behaviour
// - Scan counter pulses every N counts, 1..65536
// - Counters use internal timebases or external source
// - Armed scan counter times only after trigger
// - Start strobe triggers; external trigger left high
// - Falling external trigger starts acquisition
// - One conversion per sample interval until zero
// - Pretrigger: count only after second trigger
// - Report FIFO nonempty and half-full flags
// - Overrun or overflow halts; clear strobe recovers
// - Clean run returns to idle state
// - External convert falling edges, after trigger only
`timescale 1ns/1ps
module asc_top #(
   parameter int FIFO_DEPTH = asc_pkg::FIFO_DEPTH,
   parameter int CFG_DEPTH = asc_pkg::CFG_DEPTH
) (
   input wire logic clock,
   input wire logic rst,
   input wire logic [2:0] scan_tb_sel,
   input wire logic [2:0] sample_tb_sel,
   input wire logic [15:0] scan_interval,
   input wire logic [15:0] sample_interval,
   input wire logic [15:0] sample_count,
   input wire logic scan_enable,
   input wire logic pretrigger_mode,
   input wire logic ext_convert_mode,
   input wire logic external_count_source,
   input wire logic ext_trigger_n,
   input wire logic ext_convert_n,
   input wire logic acquisition_start_strobe,
   input wire logic acquisition_clear_strobe,
   input wire logic cfg_clear_strobe,
   input wire logic cfg_write_strobe,
   input wire logic [5:0] cfg_channel,
   input wire logic [2:0] cfg_gain,
   input wire logic final_entry_flag,
   input wire logic cfg_load_strobe,
   input wire logic conv_busy,
   input wire logic conv_valid,
   input wire logic [15:0] conv_data,
   input wire logic fifo_read,
   output logic convert_start,
   output logic [5:0] conv_channel,
   output logic [2:0] conv_gain,
   output logic [15:0] fifo_data,
   output logic result_fifo_nonempty_n,
   output logic result_fifo_half_n,
   output logic overrun_flag,
   output logic overflow_flag,
   output logic acquiring
);
   localparam int AW = $clog2(FIFO_DEPTH);
   localparam int CW = $clog2(CFG_DEPTH);

   asc_pkg::asc_state_t state_reg;                  // Acquisition state
   logic [3:0] tb_cnt_reg [0:asc_pkg::TB_STAGES-1];  // Ladder stage counters
   logic [asc_pkg::TB_STAGES-1:0] tb_en_reg;         // Timebase enables
   logic [asc_pkg::TB_STAGES-1:0] tb_carry;          // Stage advance condition
   logic src_d_reg, trig_d_reg, conv_d_reg;          // Edge detector history
   logic src_tick, trig, ext_conv_fall;              // Edge events
   logic scan_tick, sample_tick, scan_pulse, sample_pulse;
   logic active, restart, req, finish, overrun_ev, overflow_ev;
   logic [9:0] cfg_mem [0:CFG_DEPTH-1]; // {final, gain, channel}
   logic [CW-1:0] cfg_wr_reg, entry_reg;             // Write and scan pointers
   logic cfg_loaded_reg;                             // Sequence ready for use
   logic scan_pause_reg;                             // Waiting for next scan pulse
   logic [16:0] smp_cnt_reg;                         // Remaining counted samples
   logic [16:0] smp_load;                            // Sample count, 0 = 65536
   localparam int DATA_W_L = asc_pkg::DATA_W;
   logic [DATA_W_L-1:0] fifo_mem [0:FIFO_DEPTH-1];   // Result storage
   logic [AW-1:0] wr_ptr_reg, rd_ptr_reg;            // FIFO pointers
   logic [AW:0] fifo_cnt_reg;                        // FIFO fill level
   logic fifo_wr, fifo_rd;                           // FIFO transfers
   logic [15:0] fifo_data_reg;                       // Read data
   logic conv_start_reg;                             // Convert strobe
   logic [5:0] conv_chan_reg;                        // Channel of conversion
   logic [2:0] conv_gain_reg;                        // Gain of conversion
   logic overrun_reg, overflow_reg;                  // Sticky error flags

   ////////////////////////////////////////////////////////////////////////
   // Timebase ladder: stage 0 divides the clock, each later stage the enable of the one before
   assign tb_carry = {tb_en_reg[asc_pkg::TB_STAGES-2:0], 1'b1};
   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         tb_en_reg <= '0;
         for (int i = 0; i < asc_pkg::TB_STAGES; i++) begin
            tb_cnt_reg[i] <= 4'h0;
         end
      end else begin
         for (int i = 0; i < asc_pkg::TB_STAGES; i++) begin
            tb_en_reg[i] <= 1'b0;
            if (tb_carry[i]) begin
               if (tb_cnt_reg[i] == 4'(asc_pkg::TB_DIV[i] - 1)) begin
                  tb_cnt_reg[i] <= 4'h0;
                  tb_en_reg[i] <= 1'b1;
               end else begin
                  tb_cnt_reg[i] <= tb_cnt_reg[i] + 4'h1;
               end
            end
         end
      end
   end

   // Edge history of the external pins
   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         src_d_reg <= 1'b0;
         trig_d_reg <= 1'b1;
         conv_d_reg <= 1'b1;
      end else begin
         src_d_reg <= external_count_source;
         trig_d_reg <= ext_trigger_n;
         conv_d_reg <= ext_convert_n;
      end
   end

   assign src_tick = external_count_source && !src_d_reg;
   assign ext_conv_fall = conv_d_reg && !ext_convert_n;
   assign trig = acquisition_start_strobe || (trig_d_reg && !ext_trigger_n);

   // Count clock select: internal ladder or external rising edge
   function automatic logic pick_tick(input logic [2:0] sel, input logic [5:0] en,
                                      input logic ext);
      if (sel == asc_pkg::TB_SEL_EXT) begin
         return ext;
      end
      return (sel < 3'h6) ? en[sel] : 1'b0;
   endfunction
   assign scan_tick = pick_tick(scan_tb_sel, tb_en_reg, src_tick);
   assign sample_tick = pick_tick(sample_tb_sel, tb_en_reg, src_tick);

   ////////////////////////////////////////////////////////////////////////
   // Interval counters, reloaded to their armed count on every start
   assign active = (state_reg == asc_pkg::ASC_PRE) || (state_reg == asc_pkg::ASC_RUN);
   assign restart = (state_reg == asc_pkg::ASC_IDLE) || acquisition_clear_strobe;

   asc_interval_counter #(.W(16)) scan_ctr (
      .clock(clock), .rst(rst), .restart(restart), .run(active && scan_enable),
      .tick(scan_tick), .load_value(scan_interval), .pulse(scan_pulse));
   asc_interval_counter #(.W(16)) sample_ctr (
      .clock(clock), .rst(rst), .restart(restart), .run(active && !ext_convert_mode),
      .tick(sample_tick), .load_value(sample_interval), .pulse(sample_pulse));

   // Conversion request: paced by the sample counter or the convert pin
   assign req = active && cfg_loaded_reg && !(scan_enable && scan_pause_reg)
                && (ext_convert_mode ? ext_conv_fall : sample_pulse);
   assign overrun_ev = req && conv_busy;
   // The last issued conversion lands after the run ends; a halt drops late results
   assign fifo_wr = conv_valid && (state_reg != asc_pkg::ASC_HALT);
   assign overflow_ev = fifo_wr && (fifo_cnt_reg == (AW+1)'(FIFO_DEPTH));
   assign finish = (state_reg == asc_pkg::ASC_RUN) && req && (smp_cnt_reg == 17'h00001);
   assign smp_load = (sample_count == 16'h0000) ? 17'h10000 : {1'b0, sample_count};

   ////////////////////////////////////////////////////////////////////////
   // Acquisition state machine
   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         state_reg <= asc_pkg::ASC_IDLE;
      end else if (acquisition_clear_strobe) begin
         state_reg <= asc_pkg::ASC_IDLE;
      end else begin
         case (state_reg)
            asc_pkg::ASC_IDLE: begin
               if (trig) begin
                  state_reg <= pretrigger_mode ? asc_pkg::ASC_PRE : asc_pkg::ASC_RUN;
               end
            end
            asc_pkg::ASC_PRE: begin
               if (overrun_ev || overflow_ev) begin
                  state_reg <= asc_pkg::ASC_HALT;
               end else if (trig) begin
                  state_reg <= asc_pkg::ASC_RUN;
               end
            end
            asc_pkg::ASC_RUN: begin
               if (overrun_ev || overflow_ev) begin
                  state_reg <= asc_pkg::ASC_HALT;
               end else if (finish) begin
                  state_reg <= asc_pkg::ASC_IDLE;
               end
            end
            asc_pkg::ASC_HALT: begin
               state_reg <= asc_pkg::ASC_HALT;
            end
            default: begin
               state_reg <= asc_pkg::ASC_IDLE;
            end
         endcase
      end
   end

   // Sample counter: reloaded when idle, decremented only while counting
   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         smp_cnt_reg <= 17'h10000;
      end else if (state_reg == asc_pkg::ASC_IDLE) begin
         smp_cnt_reg <= smp_load;
      end else if (state_reg == asc_pkg::ASC_RUN && req) begin
         smp_cnt_reg <= smp_cnt_reg - 17'h00001;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Channel configuration memory, written in order from the host
   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         cfg_wr_reg <= '0;
         cfg_loaded_reg <= 1'b0;
      end else if (cfg_clear_strobe) begin
         cfg_wr_reg <= '0;
         cfg_loaded_reg <= 1'b0;
      end else if (cfg_write_strobe) begin
         cfg_wr_reg <= cfg_wr_reg + 1'b1;
      end else if (cfg_load_strobe) begin
         cfg_loaded_reg <= 1'b1;
      end
   end

   // Entry storage has no reset; the scan runs to the entry flagged final or to the last entry, written or not
   always_ff @(posedge clock) begin
      if (cfg_write_strobe && !cfg_clear_strobe) begin
         cfg_mem[cfg_wr_reg] <= {final_entry_flag, cfg_gain, cfg_channel};
      end
   end

   // Scan pointer: restart on scan pulse, pause after the final entry
   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         entry_reg <= '0;
         scan_pause_reg <= 1'b0;
      end else if (!active) begin
         entry_reg <= '0;
         scan_pause_reg <= 1'b0;
      end else if (req) begin
         // A conversion on a scan pulse still steps past its entry; too short an
         // interval therefore loses that restart
         if (cfg_mem[entry_reg][9] || entry_reg == CW'(CFG_DEPTH - 1)) begin
            entry_reg <= '0;
            scan_pause_reg <= !scan_pulse;
         end else begin
            entry_reg <= entry_reg + 1'b1;
            scan_pause_reg <= 1'b0;
         end
      end else if (scan_pulse) begin
         entry_reg <= '0;
         scan_pause_reg <= 1'b0;
      end
   end

   // Convert strobe with the entry it converts
   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         conv_start_reg <= 1'b0;
         conv_chan_reg <= 6'h00;
         conv_gain_reg <= 3'h0;
      end else begin
         conv_start_reg <= req && !conv_busy;
         if (req) begin
            conv_chan_reg <= cfg_mem[entry_reg][5:0];
            conv_gain_reg <= cfg_mem[entry_reg][8:6];
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Sticky error flags; a new event wins over a clear in the same cycle
   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         overrun_reg <= 1'b0;
         overflow_reg <= 1'b0;
      end else begin
         overrun_reg <= overrun_ev || (overrun_reg && !acquisition_clear_strobe);
         overflow_reg <= overflow_ev || (overflow_reg && !acquisition_clear_strobe);
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Result FIFO; cleared by the clear strobe
   assign fifo_rd = fifo_read && (fifo_cnt_reg != '0);
   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         wr_ptr_reg <= '0;
         rd_ptr_reg <= '0;
         fifo_cnt_reg <= '0;
         fifo_data_reg <= 16'h0000;
      end else if (acquisition_clear_strobe) begin
         wr_ptr_reg <= '0;
         rd_ptr_reg <= '0;
         fifo_cnt_reg <= '0;
      end else begin
         if (fifo_rd) begin
            fifo_data_reg <= fifo_mem[rd_ptr_reg];
            rd_ptr_reg <= rd_ptr_reg + 1'b1;
         end
         if (fifo_wr && !overflow_ev) begin
            wr_ptr_reg <= wr_ptr_reg + 1'b1;
         end
         fifo_cnt_reg <= fifo_cnt_reg + (AW+1)'(fifo_wr && !overflow_ev)
                         - (AW+1)'(fifo_rd);
      end
   end

   // Storage write, no reset needed
   always_ff @(posedge clock) begin
      if (fifo_wr && !overflow_ev && !acquisition_clear_strobe) begin
         fifo_mem[wr_ptr_reg] <= conv_data;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Outputs
   assign result_fifo_nonempty_n = (fifo_cnt_reg == '0);
   assign result_fifo_half_n = (fifo_cnt_reg < (AW+1)'(asc_pkg::FIFO_HALF));
   assign fifo_data = fifo_data_reg;
   assign convert_start = conv_start_reg;
   assign conv_channel = conv_chan_reg;
   assign conv_gain = conv_gain_reg;
   assign overrun_flag = overrun_reg;
   assign overflow_flag = overflow_reg;
   assign acquiring = active;

   ////////////////////////////////////////////////////////////////////////
   // Checks
   halt_on_error_a: assert property (@(posedge clock) disable iff (rst)
      active && (overrun_ev || overflow_ev) && !acquisition_clear_strobe
      |=> state_reg == asc_pkg::ASC_HALT && (overrun_flag || overflow_flag))
      else $error("error did not halt acquisition");
   halt_holds_a: assert property (@(posedge clock) disable iff (rst)
      state_reg == asc_pkg::ASC_HALT && !acquisition_clear_strobe
      |=> state_reg == asc_pkg::ASC_HALT && !convert_start)
      else $error("halted acquisition resumed without clear");
   run_done_a: assert property (@(posedge clock) disable iff (rst)
      finish && !overrun_ev && !overflow_ev && !acquisition_clear_strobe
      |=> state_reg == asc_pkg::ASC_IDLE ##1 smp_cnt_reg == $past(smp_load))
      else $error("finished run did not return to idle");
   pre_no_count_a: assert property (@(posedge clock) disable iff (rst)
      state_reg == asc_pkg::ASC_PRE ##1 state_reg == asc_pkg::ASC_PRE
      |-> $stable(smp_cnt_reg))
      else $error("sample count moved before second trigger");
   sample_count_a: assert property (@(posedge clock) disable iff (rst)
      state_reg == asc_pkg::ASC_RUN && req && !finish && !acquisition_clear_strobe
      |=> smp_cnt_reg == $past(smp_cnt_reg) - 17'h00001)
      else $error("conversion not counted");
   trig_start_a: assert property (@(posedge clock) disable iff (rst)
      state_reg == asc_pkg::ASC_IDLE && $fell(ext_trigger_n) && !acquisition_clear_strobe
      |=> active)
      else $error("external trigger ignored");
   idle_quiet_a: assert property (@(posedge clock) disable iff (rst)
      !active |=> !convert_start)
      else $error("conversion without trigger");
   half_flag_a: assert property (@(posedge clock) disable iff (rst)
      !result_fifo_half_n |-> !result_fifo_nonempty_n
      && fifo_cnt_reg >= (AW+1)'(asc_pkg::FIFO_HALF))
      else $error("half flag inconsistent with fill level");
   scan_restart_a: assert property (@(posedge clock) disable iff (rst)
      scan_pulse |=> !scan_pause_reg && (entry_reg == '0 || $past(req)))
      else $error("scan pulse did not restart the sequence");
endmodule

// ===== verification/asc_conv_model.sv
// Converter model on the far side of the acquisition block.
// Assumes convert_start is a one-cycle pulse on clock.
`timescale 1ns/1ps
module asc_conv_model (
   input wire logic clock,
   input wire logic rst,
   input wire logic convert_start,
   input wire logic [5:0] conv_channel,
   input wire logic [2:0] conv_gain,
   input wire logic [7:0] busy_len,
   output logic conv_busy,
   output logic conv_valid,
   output logic [15:0] conv_data
);
   logic [7:0] left_reg; // Busy cycles still to run
   logic [6:0] seq_reg; // Result sequence number
   ////////////////////////////////////////////////////////////////////////
   // Busy for busy_len cycles, then one result pulse; data never lingers
   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         left_reg <= 8'h00;
         seq_reg <= 7'h00;
         conv_valid <= 1'b0;
         conv_data <= 16'h0000;
      end else begin
         conv_valid <= (left_reg == 8'h01);
         if (convert_start) begin
            left_reg <= busy_len;
         end else if (left_reg != 8'h00) begin
            left_reg <= left_reg - 8'h01;
         end
         if (left_reg == 8'h01) begin
            conv_data <= {conv_channel, conv_gain, seq_reg};
            seq_reg <= seq_reg + 7'h01;
         end else begin
            conv_data <= ~conv_data;
         end
      end
   end
   assign conv_busy = (left_reg != 8'h00);
endmodule

// ===== verification/asc_top_tb.sv
// Self-checking bench for the scan acquisition control block.
// Assumes the converter model answers every convert_start.
`timescale 1ns/1ps
module asc_top_tb;
   logic clock, rst, scan_enable, pretrigger_mode, ext_convert_mode;
   logic external_count_source, ext_trigger_n, ext_convert_n, fifo_read;
   logic acquisition_start_strobe, acquisition_clear_strobe, cfg_clear_strobe;
   logic cfg_write_strobe, final_entry_flag, cfg_load_strobe, conv_busy, conv_valid;
   logic convert_start, result_fifo_nonempty_n, result_fifo_half_n;
   logic overrun_flag, overflow_flag, acquiring;
   logic [2:0] scan_tb_sel, sample_tb_sel, cfg_gain, conv_gain;
   logic [5:0] cfg_channel, conv_channel;
   logic [7:0] busy_len;
   logic [15:0] scan_interval, sample_interval, sample_count, conv_data, fifo_data;
   logic [5:0] chans [$]; // Channel of each conversion
   int starts [$]; // Cycle of each conversion
   int cyc, err_total, n_checks, n0;
   asc_top asc_top_inst (.*);
   asc_conv_model asc_conv_model_inst (.*);
   ////////////////////////////////////////////////////////////////////////
   // Clock, external count source and conversion log with hang limit
   initial begin
      clock = 1'b0;
      forever #20 clock = ~clock;
   end
   // External count source toggles on falling edges, one rising edge per 6 cycles
   always begin
      repeat (3) @(negedge clock);
      external_count_source = ~external_count_source;
   end
   always @(posedge clock) begin
      cyc++;
      if (convert_start === 1'b1) begin
         chans.push_back(conv_channel);
         starts.push_back(cyc);
      end
      if (cyc > 20000) begin
         err_total++;
         report_and_stop();
      end
   end
   ////////////////////////////////////////////////////////////////////////
   task automatic step(input int n);
      repeat (n) @(negedge clock);
   endtask
   task automatic chk(input logic [15:0] got, input logic [15:0] exp);
      n_checks++;
      if (got !== exp) begin
         err_total++;
         $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   task automatic pulse(ref logic s);
      s = 1'b1;
      step(1);
      s = 1'b0;
   endtask
   task automatic low_pulse(ref logic s);
      s = 1'b0;
      step(2);
      s = 1'b1;
      step(6);
   endtask
   task automatic fresh;
      chans.delete();
      starts.delete();
   endtask
   // Two entries: channel 5 gain 1, channel 9 gain 2 flagged final
   task automatic cfg_load;
      pulse(cfg_clear_strobe);
      {cfg_channel, cfg_gain, cfg_write_strobe} = {6'h05, 3'h1, 1'b1};
      step(1);
      {cfg_channel, cfg_gain, final_entry_flag} = {6'h09, 3'h2, 1'b1};
      step(1);
      {cfg_write_strobe, final_entry_flag} = 2'h0;
      pulse(cfg_load_strobe);
   endtask
   task automatic wait_idle;
      for (int k = 0; k < 8000 && acquiring === 1'b1; k++) step(1);
      step(6);
   endtask
   // Read held high so back-to-back pops; channel field alternates
   task automatic drain(input int n);
      fifo_read = 1'b1;
      for (int i = 0; i < n; i++) begin
         step(1);
         chk(fifo_data[15:7], i[0] ? 9'h04A : 9'h029);
      end
      fifo_read = 1'b0;
      step(2);
      chk(result_fifo_nonempty_n, 1'b1);
   endtask
   task automatic report_and_stop;
      $display("checks=%0d errors=%0d", n_checks, err_total);
      if (err_total == 0 && n_checks > 0)
         $display("STATUS OK");
      else
         $display("STATUS NOT OK");
      $finish;
   endtask
   ////////////////////////////////////////////////////////////////////////
   initial begin
      {scan_enable, pretrigger_mode, ext_convert_mode, external_count_source} = 4'h0;
      {acquisition_start_strobe, acquisition_clear_strobe, fifo_read} = 3'h0;
      {cfg_clear_strobe, cfg_write_strobe, final_entry_flag, cfg_load_strobe} = 4'h0;
      {ext_trigger_n, ext_convert_n, rst} = 3'h7;
      {scan_tb_sel, sample_tb_sel, cfg_channel, cfg_gain} = 15'h0000;
      scan_interval = 16'h0014;
      {sample_interval, sample_count, busy_len} = {16'h0002, 16'h0004, 8'h02};
      step(8);
      rst = 1'b0;
      cfg_load();
      // Software start, entries cycling freely
      pulse(acquisition_start_strobe);
      chk(acquiring, 1'b1);
      wait_idle();
      chk(chans.size(), 4);
      chk(starts[1] - starts[0], 10);
      chk(result_fifo_nonempty_n, 1'b0);
      drain(4);
      // External trigger, same settings rerun on the 1 MHz timebase
      fresh();
      sample_tb_sel = 3'h1;
      low_pulse(ext_trigger_n);
      wait_idle();
      chk(chans.size(), 4);
      chk(starts[1] - starts[0], 50);
      drain(4);
      sample_tb_sel = 3'h0;
      // Pretrigger: only conversions after the second trigger count
      pretrigger_mode = 1'b1;
      pulse(acquisition_start_strobe);
      step(100);
      chk(acquiring, 1'b1);
      n0 = chans.size();
      low_pulse(ext_trigger_n);
      wait_idle();
      chk((chans.size() - n0) inside {4, 5}, 1'b1);
      pretrigger_mode = 1'b0;
      pulse(acquisition_clear_strobe);
      step(2);
      chk(result_fifo_nonempty_n, 1'b1);
      // Half-full flag after 256 results
      sample_count = 16'h0100;
      pulse(acquisition_start_strobe);
      wait_idle();
      chk(result_fifo_half_n, 1'b0);
      pulse(acquisition_clear_strobe);
      step(2);
      chk(result_fifo_half_n, 1'b1);
      // Overflow: 514 results into 512 words halts on the 513th
      sample_count = 16'h0202;
      pulse(acquisition_start_strobe);
      wait_idle();
      chk(overflow_flag, 1'b1);
      pulse(acquisition_clear_strobe);
      sample_count = 16'h0004;
      // Slow converter on the external source: overrun halts
      {sample_tb_sel, busy_len} = {3'h6, 8'h20};
      pulse(acquisition_start_strobe);
      wait_idle();
      chk(overrun_flag, 1'b1);
      chk(overflow_flag, 1'b0);
      step(30); // Let the busy converter finish while halted
      pulse(acquisition_clear_strobe);
      step(2);
      chk(overrun_flag, 1'b0);
      {sample_tb_sel, busy_len} = {3'h0, 8'h02};
      // External convert: ignored before trigger and after count ends
      ext_convert_mode = 1'b1;
      fresh();
      low_pulse(ext_convert_n);
      chk(chans.size(), 0);
      pulse(acquisition_start_strobe);
      repeat (5) low_pulse(ext_convert_n);
      chk(chans.size(), 4);
      ext_convert_mode = 1'b0;
      pulse(acquisition_clear_strobe);
      // Scan pacing: pause after final entry until next scan pulse
      scan_enable = 1'b1;
      fresh();
      pulse(acquisition_start_strobe);
      wait_idle();
      for (int i = 0; i < 4; i++) chk(chans[i], i[0] ? 6'h09 : 6'h05);
      chk((starts[2] - starts[0]) inside {100, 110}, 1'b1);
      drain(4);
      report_and_stop();
   end
endmodule
